// [verilog/timer_pair_ctrl.sv]
// Module: two-channel 8-bit timer control/status logic with AXI4-Lite access
//
// Decided for this implementation: the register addresses and register access over AXI4-Lite.
`timescale 1ns/10ps
//
// Overview of operation
// RL1: Y match B sets Y match B flag
// RL2: Y match A sets Y match A flag
// RL3: Y counter wrap FF to 00 sets wrap
// RL4: Flag clears only on read-while-set, then zero
// RL5: Writing one to status flags is ignored
// RL6: Capture request needs Y enable and X flag
// RL7: Y match B drives Y pin per bits 3:2
// RL8: Y match A drives Y pin per bits 1:0
// RL9: X match B sets X match B flag
// RL10: X match A sets X match A flag
// RL11: X counter wrap FF to 00 sets wrap
// RL12: Rise then fall on reset input sets capture
// RL13: Capture flag clears after read-while-one, then zero
// RL14: X match B drives X pin per bits 3:2
// RL15: X match A drives X pin per bits 1:0
// RL16: All control/status bits reset to zero
// RL17: Synchronise external reset input before edge detect
module timer_pair_ctrl #(
	parameter int ADDR_W = 8                          // AXI address width
) (
	input  wire logic              clk,
	input  wire logic              rst,
	// AXI4-Lite slave
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	// Pins and requests
	input  wire logic              ext_reset_in,
	output logic                   timer_y_output_pin,
	output logic                   timer_x_output_pin,
	output logic                   capture_irq_request,
	output logic                   irq
);

	// ------------------------------------------------------------
	// Storage
	// ------------------------------------------------------------
	localparam int EV_W_L = timer_pair_pkg::EV_W;     // Local copy for widths
	logic [7:0]            csr_y_q;                   // Y control/status
	logic [7:0]            csr_x_q;                   // X control/status
	logic [7:0]            cnt_q [2];                 // Counters, index 0 = Y, 1 = X
	logic [7:0]            cmp_a_q [2];               // Compare A constants
	logic [7:0]            cmp_b_q [2];               // Compare B constants
	logic [1:0]            pin_q;                     // Output pins, 0 = Y, 1 = X
	logic [7:0]            armed_q [2];               // Flags seen set by a csr read
	logic [EV_W_L-1:0]     ev_st_q;                   // Sticky event status
	logic [EV_W_L-1:0]     ev_msk_q;                  // Event mask
	logic [2:0]            rsync_q;                   // Synchroniser plus history stage
	logic                  rose_q;                    // Rising edge seen, awaiting fall

	// ------------------------------------------------------------
	// AXI handshake state
	// ------------------------------------------------------------
	logic [ADDR_W-1:0]     aw_q;                      // Held write address
	logic                  aw_have_q;                 // Write address taken
	logic [31:0]           wd_q;                      // Held write data
	logic [3:0]            ws_q;                      // Held strobes
	logic                  wd_have_q;                 // Write data taken
	logic                  wr_go;                     // Perform write this cycle
	logic                  rd_go;                     // Perform read this cycle
	logic [31:0]           rd_val;                    // Read mux result
	logic                  rd_hit;                    // Read address mapped
	logic                  wr_hit;                    // Write address mapped

	assign wr_go = aw_have_q && wd_have_q && !s_axi_bvalid;
	assign rd_go = s_axi_arvalid && s_axi_arready;

	// Write address/data capture, either order, one write in flight
	always_ff @(posedge clk) begin
		if (rst) begin
			aw_have_q     <= 1'b0;
			wd_have_q     <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			aw_q          <= '0;
			wd_q          <= '0;
			ws_q          <= '0;
		end else begin
			s_axi_awready <= !aw_have_q && !s_axi_awready && !s_axi_bvalid;
			s_axi_wready  <= !wd_have_q && !s_axi_wready && !s_axi_bvalid;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_have_q     <= 1'b1;
				aw_q          <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wd_have_q    <= 1'b1;
				wd_q         <= s_axi_wdata;
				ws_q         <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (wr_go) begin
				aw_have_q <= 1'b0;
				wd_have_q <= 1'b0;
			end
		end
	end

	// Write response, slave error for unmapped offsets
	always_ff @(posedge clk) begin
		if (rst) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= timer_pair_pkg::AXI_OKAY;
		end else if (wr_go) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= wr_hit ? timer_pair_pkg::AXI_OKAY : timer_pair_pkg::AXI_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// Read address decode and mux
	always_comb begin
		rd_val = 32'h0000_0000;
		rd_hit = 1'b1;
		case (s_axi_araddr[7:0])
			timer_pair_pkg::OFF_Y_CSR:   rd_val = {24'h00_0000, csr_y_q};
			timer_pair_pkg::OFF_X_CSR:   rd_val = {24'h00_0000, csr_x_q};
			timer_pair_pkg::OFF_CNT:     rd_val = {16'h0000, cnt_q[1], cnt_q[0]};
			timer_pair_pkg::OFF_CMP_Y:   rd_val = {16'h0000, cmp_b_q[0], cmp_a_q[0]};
			timer_pair_pkg::OFF_CMP_X:   rd_val = {16'h0000, cmp_b_q[1], cmp_a_q[1]};
			timer_pair_pkg::OFF_IRQ_ST:  rd_val = {25'h000_0000, ev_st_q};
			timer_pair_pkg::OFF_IRQ_MSK: rd_val = {25'h000_0000, ev_msk_q};
			default:                     rd_hit = 1'b0;
		endcase
	end

	// Write decode only flags which offset is mapped
	always_comb begin
		case (aw_q[7:0])
			timer_pair_pkg::OFF_Y_CSR,
			timer_pair_pkg::OFF_X_CSR,
			timer_pair_pkg::OFF_CNT,
			timer_pair_pkg::OFF_CMP_Y,
			timer_pair_pkg::OFF_CMP_X,
			timer_pair_pkg::OFF_IRQ_ST,
			timer_pair_pkg::OFF_IRQ_MSK: wr_hit = 1'b1;
			default:                     wr_hit = 1'b0;
		endcase
	end

	// Read channel, one read in flight
	always_ff @(posedge clk) begin
		if (rst) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= timer_pair_pkg::AXI_OKAY;
		end else begin
			s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
			if (rd_go) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid  <= 1'b1;
				s_axi_rdata   <= rd_val;
				s_axi_rresp   <= rd_hit ? timer_pair_pkg::AXI_OKAY : timer_pair_pkg::AXI_SLVERR;
			end else if (s_axi_rready && s_axi_rvalid) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// Register strobes
	// ------------------------------------------------------------
	logic       wr_y_csr;                             // Y csr write, low lane
	logic       wr_x_csr;                             // X csr write, low lane
	logic       rd_y_csr;                             // Y csr read taken
	logic       rd_x_csr;                             // X csr read taken

	assign wr_y_csr = wr_go && ws_q[0] && (aw_q[7:0] == timer_pair_pkg::OFF_Y_CSR);
	assign wr_x_csr = wr_go && ws_q[0] && (aw_q[7:0] == timer_pair_pkg::OFF_X_CSR);
	assign rd_y_csr = rd_go && (s_axi_araddr[7:0] == timer_pair_pkg::OFF_Y_CSR);
	assign rd_x_csr = rd_go && (s_axi_araddr[7:0] == timer_pair_pkg::OFF_X_CSR);

	// ------------------------------------------------------------
	// External reset input: synchronise, then rise-then-fall detect
	// ------------------------------------------------------------
	logic cap_evt;                                    // Rise-then-fall complete

	// Stage 0 is read only by stage 1, so metastability never reaches logic
	always_ff @(posedge clk) begin
		if (rst) begin
			rsync_q <= 3'b000;
		end else begin
			rsync_q <= {rsync_q[1:0], ext_reset_in};  // RL17
		end
	end

	// Remember a rise; the following fall completes the pair
	always_ff @(posedge clk) begin
		if (rst) begin
			rose_q <= 1'b0;
		end else if (rsync_q[1] && !rsync_q[2]) begin
			rose_q <= 1'b1;                           // RL12
		end else if (cap_evt) begin
			rose_q <= 1'b0;
		end
	end

	assign cap_evt = rose_q && !rsync_q[1] && rsync_q[2];  // RL12

	// ------------------------------------------------------------
	// Counters, compare constants and per-channel events
	// ------------------------------------------------------------
	logic [1:0] hit_a;                                // Compare A match pulse per channel
	logic [1:0] hit_b;                                // Compare B match pulse per channel
	logic [1:0] wrap;                                 // Wrap pulse per channel
	logic [7:0] sel_q [2];                            // Csr per channel for the generate

	assign sel_q[0] = csr_y_q;
	assign sel_q[1] = csr_x_q;

	generate
		for (genvar c = 0; c < 2; c++) begin : g_chan
			logic [7:0] cnt_off;                      // Byte lane of this counter
			// Free-running counter, software may preload its byte
			always_ff @(posedge clk) begin
				if (rst) begin
					cnt_q[c] <= timer_pair_pkg::CNT_RESET;
				end else if (wr_go && ws_q[c] && aw_q[7:0] == timer_pair_pkg::OFF_CNT) begin
					cnt_q[c] <= wd_q[8*c +: 8];
				end else begin
					cnt_q[c] <= cnt_q[c] + 8'h01;
				end
			end

			// Compare constants, A in low byte, B in next
			always_ff @(posedge clk) begin
				if (rst) begin
					cmp_a_q[c] <= timer_pair_pkg::CMP_RESET;
					cmp_b_q[c] <= timer_pair_pkg::CMP_RESET;
				end else if (wr_go && aw_q[7:0] == (c == 0 ? timer_pair_pkg::OFF_CMP_Y
				                                            : timer_pair_pkg::OFF_CMP_X)) begin
					if (ws_q[0]) begin
						cmp_a_q[c] <= wd_q[7:0];
					end
					if (ws_q[1]) begin
						cmp_b_q[c] <= wd_q[15:8];
					end
				end
			end

			assign hit_a[c] = (cnt_q[c] == cmp_a_q[c]);               // RL2 RL10
			assign hit_b[c] = (cnt_q[c] == cmp_b_q[c]);               // RL1 RL9
			assign wrap[c]  = (cnt_q[c] == timer_pair_pkg::CNT_MAX);  // RL3 RL11

			// Pin update; B action applied after A, so on a shared match a B low/high overrides A and a B toggle inverts A's result
			always_ff @(posedge clk) begin
				if (rst) begin
					pin_q[c] <= 1'b0;
				end else begin
					logic nxt;
					nxt = pin_q[c];
					if (hit_a[c]) begin
						case (sel_q[c][timer_pair_pkg::BIT_ACT_A +: 2])   // RL8 RL15
							timer_pair_pkg::ACT_LOW:    nxt = 1'b0;
							timer_pair_pkg::ACT_HIGH:   nxt = 1'b1;
							timer_pair_pkg::ACT_TOGGLE: nxt = !nxt;
							default:                    nxt = nxt;
						endcase
					end
					if (hit_b[c]) begin
						case (sel_q[c][timer_pair_pkg::BIT_ACT_B +: 2])   // RL7 RL14
							timer_pair_pkg::ACT_LOW:    nxt = 1'b0;
							timer_pair_pkg::ACT_HIGH:   nxt = 1'b1;
							timer_pair_pkg::ACT_TOGGLE: nxt = !nxt;
							default:                    nxt = nxt;
						endcase
					end
					pin_q[c] <= nxt;
				end
			end
		end
	endgenerate

	assign timer_y_output_pin = pin_q[0];
	assign timer_x_output_pin = pin_q[1];

	// ------------------------------------------------------------
	// Control/status registers
	// ------------------------------------------------------------
	logic [7:0] set_y;                                // Hardware flag sets, Y
	logic [7:0] set_x;                                // Hardware flag sets, X
	logic [7:0] flag_m;                               // Flag bit positions, channel common

	assign flag_m = 8'hE0;
	assign set_y  = {hit_b[0], hit_a[0], wrap[0], 5'h00};              // RL1 RL2 RL3
	assign set_x  = {hit_b[1], hit_a[1], wrap[1], cap_evt, 4'h0};      // RL9 RL10 RL11 RL12

	// Flags read while set are armed; the next csr write may clear them
	always_ff @(posedge clk) begin
		if (rst) begin
			armed_q[0] <= 8'h00;
			armed_q[1] <= 8'h00;
		end else begin
			if (rd_y_csr) begin
				armed_q[0] <= csr_y_q & flag_m;                       // RL4
			end else if (wr_y_csr) begin
				armed_q[0] <= 8'h00;
			end
			if (rd_x_csr) begin
				armed_q[1] <= csr_x_q & (flag_m | 8'h10);             // RL13
			end else if (wr_x_csr) begin
				armed_q[1] <= 8'h00;
			end
		end
	end

	// Zero write clears only armed flags, ones ignored, hardware set wins
	always_ff @(posedge clk) begin
		if (rst) begin
			csr_y_q <= timer_pair_pkg::CSR_RESET;                     // RL16
			csr_x_q <= timer_pair_pkg::CSR_RESET;                     // RL16
		end else begin
			if (wr_y_csr) begin
				csr_y_q <= ((csr_y_q & flag_m & ~(armed_q[0] & ~wd_q[7:0]))  // RL4 RL5
				            | (wd_q[7:0] & ~flag_m)) | set_y;
			end else begin
				csr_y_q <= csr_y_q | set_y;
			end
			if (wr_x_csr) begin
				csr_x_q <= ((csr_x_q & 8'hF0 & ~(armed_q[1] & ~wd_q[7:0]))   // RL13 RL5
				            | (wd_q[7:0] & 8'h0F)) | set_x;
			end else begin
				csr_x_q <= csr_x_q | set_x;
			end
		end
	end

	// ------------------------------------------------------------
	// Interrupts
	// ------------------------------------------------------------
	logic [EV_W_L-1:0] ev_set;                         // Event pulses

	assign ev_set = {cap_evt, hit_b[1], hit_a[1], wrap[1], hit_b[0], hit_a[0], wrap[0]};

	// Sticky status, write one clears, set beats clear
	always_ff @(posedge clk) begin
		if (rst) begin
			ev_st_q  <= '0;
			ev_msk_q <= '0;
		end else begin
			if (wr_go && ws_q[0] && aw_q[7:0] == timer_pair_pkg::OFF_IRQ_ST) begin
				ev_st_q <= (ev_st_q & ~wd_q[EV_W_L-1:0]) | ev_set;
			end else begin
				ev_st_q <= ev_st_q | ev_set;
			end
			if (wr_go && ws_q[0] && aw_q[7:0] == timer_pair_pkg::OFF_IRQ_MSK) begin
				ev_msk_q <= wd_q[EV_W_L-1:0];
			end
		end
	end

	// Registered request outputs
	always_ff @(posedge clk) begin
		if (rst) begin
			capture_irq_request <= 1'b0;
			irq                 <= 1'b0;
		end else begin
			capture_irq_request <= csr_y_q[timer_pair_pkg::BIT_BIT4]   // RL6
			                       && csr_x_q[timer_pair_pkg::BIT_BIT4];
			irq                 <= |(ev_st_q & ev_msk_q);
		end
	end

endmodule

// [verilog/timer_pair_pkg.sv]
// Package: register map, field positions and carrier types for the timer pair block
package timer_pair_pkg;

	// ------------------------------------------------------------
	// Register byte offsets
	// ------------------------------------------------------------
	localparam logic [7:0] OFF_Y_CSR   = 8'h00;       // Channel Y control/status
	localparam logic [7:0] OFF_X_CSR   = 8'h04;       // Channel X control/status
	localparam logic [7:0] OFF_CNT     = 8'h08;       // Counters, Y in [7:0], X in [15:8]
	localparam logic [7:0] OFF_CMP_Y   = 8'h0C;       // Y compare A [7:0], B [15:8]
	localparam logic [7:0] OFF_CMP_X   = 8'h10;       // X compare A [7:0], B [15:8]
	localparam logic [7:0] OFF_IRQ_ST  = 8'h14;       // Sticky event status, write one clears
	localparam logic [7:0] OFF_IRQ_MSK = 8'h18;       // Interrupt mask, one enables

	// ------------------------------------------------------------
	// Control/status field positions
	// ------------------------------------------------------------
	localparam int BIT_MATCH_B = 7;                   // Compare-match B flag
	localparam int BIT_MATCH_A = 6;                   // Compare-match A flag
	localparam int BIT_WRAP    = 5;                   // Overflow flag
	localparam int BIT_BIT4    = 4;                   // Y: capture enable, X: capture flag
	localparam int BIT_ACT_B   = 2;                   // Low bit of match B action field
	localparam int BIT_ACT_A   = 0;                   // Low bit of match A action field

	// ------------------------------------------------------------
	// Reset values and event status layout
	// ------------------------------------------------------------
	localparam logic [7:0] CSR_RESET   = 8'h00;       // All flags, enables, selects clear
	localparam logic [7:0] CNT_RESET   = 8'h00;       // Counter start value
	localparam logic [7:0] CNT_MAX     = 8'hFF;       // Value from which a wrap occurs
	localparam logic [7:0] CMP_RESET   = 8'hFF;       // Compare constant start value
	localparam int         EV_W        = 7;           // Event bits: Y B,A,W  X B,A,W  capture
	localparam logic [1:0] AXI_OKAY    = 2'h0;        // Bus response OKAY
	localparam logic [1:0] AXI_SLVERR  = 2'h2;        // Bus response for unmapped address

	// Output action coding of each two-bit field
	typedef enum logic [1:0] {
		ACT_KEEP   = 2'b00,
		ACT_LOW    = 2'b01,
		ACT_HIGH   = 2'b10,
		ACT_TOGGLE = 2'b11
	} out_action_t;

	// Per-channel status bits carried together
	typedef struct packed {
		logic match_b_flag;                           // Compare-match B
		logic match_a_flag;                           // Compare-match A
		logic wrap_flag;                              // Overflow
	} chan_flags_t;

endpackage

// [verif/timer_pair_ctrl_asserts.sv]
// Checker: concurrent properties on the ports of the timer pair control block
`timescale 1ns/10ps
module timer_pair_ctrl_asserts #(
	parameter int ADDR_W = 8                      // Address width of the watched slave
) (
	input wire logic              clk,
	input wire logic              rst,
	input wire logic              s_axi_awvalid,
	input wire logic              s_axi_awready,
	input wire logic              s_axi_wvalid,
	input wire logic              s_axi_wready,
	input wire logic [1:0]        s_axi_bresp,
	input wire logic              s_axi_bvalid,
	input wire logic              s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic              s_axi_arvalid,
	input wire logic              s_axi_arready,
	input wire logic [31:0]       s_axi_rdata,
	input wire logic [1:0]        s_axi_rresp,
	input wire logic              s_axi_rvalid,
	input wire logic              s_axi_rready,
	input wire logic              ext_reset_in,
	input wire logic              timer_y_output_pin,
	input wire logic              timer_x_output_pin,
	input wire logic              capture_irq_request,
	input wire logic              irq
);
	// ------------------------------------------------------------
	// Helper: age of the last possible cause of a capture request
	// ------------------------------------------------------------
	logic [3:0] since_q;                          // Saturates so it never wraps back to young
	always_ff @(posedge clk) begin
		if (rst || (s_axi_wvalid && s_axi_wready) || $fell(ext_reset_in)) begin
			since_q <= 4'h0;
		end else if (since_q != 4'hF) begin
			since_q <= since_q + 4'h1;
		end
	end

	// ------------------------------------------------------------
	// Properties
	// ------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	sequence aw_w_taken_s;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence ar_taken_s;
		s_axi_arvalid && s_axi_arready;
	endsequence
	sequence slverr_s;
		s_axi_rvalid && (s_axi_rresp == timer_pair_pkg::AXI_SLVERR) && (s_axi_rdata == 32'h0000_0000);
	endsequence
	reset_quiet_a: assert property ($fell(rst) |-> !s_axi_bvalid && !s_axi_rvalid && !irq
		&& !timer_y_output_pin && !timer_x_output_pin && !capture_irq_request)
		else $error("outputs not clear after reset");
	ready_after_a: assert property ($fell(rst) |-> ##[0:2] (s_axi_awready && s_axi_arready))
		else $error("slave not ready after reset");
	write_answer_a: assert property (aw_w_taken_s |-> ##[1:2] s_axi_bvalid)
		else $error("write response missing");
	read_answer_a: assert property (ar_taken_s |-> ##[1:2] s_axi_rvalid)
		else $error("read response missing");
	unmapped_read_a: assert property ((ar_taken_s ##0
		(s_axi_araddr > ADDR_W'(timer_pair_pkg::OFF_IRQ_MSK))) |-> ##[1:2] slverr_s)
		else $error("unmapped read not refused");
	bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	capture_cause_a: assert property ($rose(capture_irq_request) |-> since_q < 4'hC)
		else $error("capture request without cause");
endmodule

bind timer_pair_ctrl timer_pair_ctrl_asserts #(.ADDR_W(ADDR_W)) u_chk (.clk(clk), .rst(rst),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
	.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .ext_reset_in(ext_reset_in),
	.timer_y_output_pin(timer_y_output_pin), .timer_x_output_pin(timer_x_output_pin),
	.capture_irq_request(capture_irq_request), .irq(irq));

// [verif/timer_pair_ctrl_tb.sv]
// Testbench: bus-driven scenarios for the timer pair control block
`timescale 1ns/10ps
`define CMP(a, e) begin n_tests++; if ((a) !== (e)) begin failures++; \
	$display("BAD t=%0t act=%h exp=%h", $time, (a), (e)); end end
module timer_pair_ctrl_tb;
	// Expectation note: bits that matter and expected {resp, data}
	typedef struct packed {
		logic [31:0] m;
		logic [33:0] e;
	} note_t;
	// ------------------------------------------------------------
	// Signals and constants
	// ------------------------------------------------------------
	localparam logic [7:0] y_csr = timer_pair_pkg::OFF_Y_CSR;
	localparam logic [7:0] x_csr = timer_pair_pkg::OFF_X_CSR;
	localparam logic [7:0] st_a  = timer_pair_pkg::OFF_IRQ_ST;
	localparam logic [7:0] msk_a = timer_pair_pkg::OFF_IRQ_MSK;
	logic        clk = 1'b0, rst = 1'b1, ext = 1'b0, snap = 1'b0;
	logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [7:0]  awaddr = 8'h00, araddr = 8'h00, ca, cb;       // ca, cb: random compares
	logic [31:0] wdata = 32'h0000_0000, rdata;
	logic [1:0]  bresp, rresp;
	logic        awready, wready, bvalid, arready, rvalid, y_pin, x_pin, cap_req, irq, pin;
	logic [33:0] act;                                          // Observed {resp, data}
	note_t       notes[$], cur;                                // Oldest expectation first
	int          failures = 0, n_tests = 0, cyc = 0;
	logic [7:0]  offs[2] = '{y_csr, x_csr};
	timer_pair_pkg::out_action_t codes[5] = '{timer_pair_pkg::ACT_HIGH, timer_pair_pkg::ACT_KEEP,
		timer_pair_pkg::ACT_TOGGLE, timer_pair_pkg::ACT_TOGGLE, timer_pair_pkg::ACT_LOW};

	timer_pair_ctrl DUT (.clk(clk), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.ext_reset_in(ext), .timer_y_output_pin(y_pin), .timer_x_output_pin(x_pin),
		.capture_irq_request(cap_req), .irq(irq));

	always #2 clk = !clk;

	// Cycle ceiling, far above the thousand or so cycles the tests need
	always @(posedge clk) begin
		cyc++;
		if (cyc == 8000) begin
			failures++;
			final_report();
		end
	end

	// Monitor: each bus answer or pin snapshot takes the oldest note
	always @(posedge clk) begin
		if ((rvalid && rready) || (bvalid && bready) || snap) begin
			cur = notes.pop_front();
			act = snap ? {30'h0000_0000, irq, cap_req, x_pin, y_pin} : {rresp, rdata};
			if (bvalid && bready) act = {bresp, 32'h0000_0000};
			`CMP(act & {2'b11, cur.m}, cur.e)
		end
	end

	// ------------------------------------------------------------
	// Bus and snapshot tasks; rready comes a cycle after rvalid to exercise stalls, bready rises with bvalid
	// ------------------------------------------------------------
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] r = timer_pair_pkg::AXI_OKAY);
		notes.push_back('{32'h0000_0000, {r, 32'h0000_0000}});
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		do begin
			@(posedge clk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while ((awvalid && !awready) || (wvalid && !wready));
		@(posedge clk);
		bready <= 1'b1;
		do @(posedge clk); while (!bvalid);
		bready <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] d,
		input logic [1:0] r = timer_pair_pkg::AXI_OKAY);
		notes.push_back('{m, {r, d}});
		araddr <= a;
		arvalid <= 1'b1;
		do @(posedge clk); while (!arready);
		arvalid <= 1'b0;
		@(posedge clk);
		rready <= 1'b1;
		do @(posedge clk); while (!rvalid);
		rready <= 1'b0;
	endtask

	// Expected {irq, capture request, x pin, y pin}, after a settling wait
	task automatic pins(input logic [3:0] e);
		repeat (3) @(posedge clk);
		notes.push_back('{32'h0000_000F, {30'h0000_0000, e}});
		snap <= 1'b1;
		@(posedge clk);
		snap <= 1'b0;
	endtask

	task automatic final_report;
		$display("comparisons=%0d mismatches=%0d", n_tests, failures);
		if (failures == 0 && n_tests > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		void'($urandom(62375));
		ca = 8'h40 + 8'($urandom % 64);                       // A and B stay far apart
		cb = 8'hC0 + 8'($urandom % 64);
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		repeat (3) @(posedge clk);
		rd(y_csr, 32'h0000_00FF, 32'h0000_0000);
		rd(x_csr, 32'h0000_00FF, 32'h0000_0000);
		rd(msk_a, 32'h0000_007F, 32'h0000_0000);
		rd(8'h1C, 32'hFFFF_FFFF, 32'h0000_0000, timer_pair_pkg::AXI_SLVERR);
		wr(8'h1C, 32'h0000_0000, timer_pair_pkg::AXI_SLVERR);
		pins(4'h0);
		$display("test reset done");
		wr(timer_pair_pkg::OFF_CMP_Y, {16'h0000, cb, ca});
		wr(timer_pair_pkg::OFF_CMP_X, {16'h0000, cb, ca});
		repeat (300) @(posedge clk);
		rd(y_csr, 32'h0000_00E0, 32'h0000_00E0);
		rd(x_csr, 32'h0000_00E0, 32'h0000_00E0);
		// Counter restarted at zero so no match lands during the clear
		foreach (offs[i]) begin
			wr(timer_pair_pkg::OFF_CNT, 32'h0000_0000);
			wr(offs[i], 32'h0000_00E0);
			wr(offs[i], 32'h0000_0000);
			rd(offs[i], 32'h0000_00E0, 32'h0000_00E0);
			wr(offs[i], 32'h0000_0000);
			rd(offs[i], 32'h0000_00E0, 32'h0000_0000);
		end
		$display("test flags done");
		pin = 1'b0;
		for (int s = 0; s < 4; s += 2) begin
			foreach (codes[i]) begin
				wr(y_csr, 32'(codes[i]) << s);
				wr(x_csr, 32'(codes[i]) << s);
				wr(timer_pair_pkg::OFF_CNT, {16'h0000, {2{(s == 0 ? ca : cb) - 8'h08}}});
				repeat (20) @(posedge clk);
				case (codes[i])
					timer_pair_pkg::ACT_LOW: pin = 1'b0;
					timer_pair_pkg::ACT_HIGH: pin = 1'b1;
					timer_pair_pkg::ACT_TOGGLE: pin = !pin;
					default: pin = pin;
				endcase
				pins({2'b00, pin, pin});
			end
		end
		$display("test outputs done");
		ext <= 1'b1;
		repeat (8) @(posedge clk);
		rd(x_csr, 32'h0000_0010, 32'h0000_0000);
		ext <= 1'b0;
		repeat (8) @(posedge clk);
		rd(x_csr, 32'h0000_0010, 32'h0000_0010);
		pins({2'b00, pin, pin});
		wr(y_csr, 32'h0000_0010);
		pins({2'b01, pin, pin});
		wr(x_csr, 32'h0000_0010);
		wr(x_csr, 32'h0000_0000);
		rd(x_csr, 32'h0000_0010, 32'h0000_0010);
		wr(x_csr, 32'h0000_0000);
		rd(x_csr, 32'h0000_0010, 32'h0000_0000);
		pins({2'b00, pin, pin});
		$display("test capture done");
		rd(st_a, 32'h0000_0040, 32'h0000_0040);
		wr(msk_a, 32'h0000_0040);
		pins({2'b10, pin, pin});
		wr(st_a, 32'h0000_0040);
		pins({2'b00, pin, pin});
		rd(st_a, 32'h0000_0040, 32'h0000_0000);
		rd(msk_a, 32'h0000_007F, 32'h0000_0040);
		$display("test interrupt done");
		final_report();
	end
endmodule
